/* File: bridge_pwm_pkg.sv */
// constants and types shared by the bridge pwm output stage
`default_nettype none
package bridge_pwm_pkg;
    // register offsets
    localparam logic [2:0] OFF_DUTY_HIGH = 3'h0;
    localparam logic [2:0] OFF_CONTROL   = 3'h1;
    localparam logic [2:0] OFF_PERIOD    = 3'h2;
    localparam logic [2:0] OFF_DEADBAND  = 3'h3;
    localparam logic [2:0] OFF_DUTY_BUF  = 3'h4;
    localparam logic [2:0] OFF_TIMER_CTL = 3'h5;
    localparam logic [2:0] OFF_TIMER     = 3'h6;
    // values after reset
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam logic [7:0] RST_PERIOD    = 8'hff;
    // control register fields
    localparam int CTL_CFG_HI  = 7;
    localparam int CTL_CFG_LO  = 6;
    localparam int CTL_DLOW_HI = 5;
    localparam int CTL_DLOW_LO = 4;
    localparam int CTL_MODE_HI = 3;
    localparam int CTL_MODE_LO = 0;
    localparam int MODE_POL_AC = 1;
    localparam int MODE_POL_BD = 0;
    localparam logic [1:0] MODE_PWM_SEL = 2'h3;
    // dead-band register field
    localparam int DB_CNT_HI = 6;
    // timer control fields
    localparam int TMR_ON_BIT = 2;
    localparam int TMR_PS_HI  = 1;
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV4 = 2'h1;
    localparam logic [5:0] PRE_LAST1  = 6'h03;
    localparam logic [5:0] PRE_LAST4  = 6'h0f;
    localparam logic [5:0] PRE_LAST16 = 6'h3f;
    // timing: one instruction cycle is four oscillator periods
    localparam int TOSC_NS  = 10;
    localparam int TCY_NS   = 40;
    localparam int TCY_CLKS = (TCY_NS + TOSC_NS - 1) / TOSC_NS;
    // output arrangements
    typedef enum logic [1:0] {
        CFG_SINGLE   = 2'h0,
        CFG_FULL_FWD = 2'h1,
        CFG_HALF     = 2'h2,
        CFG_FULL_REV = 2'h3
    } outcfg_t;
endpackage : bridge_pwm_pkg
`default_nettype wire

/* File: deadband_if.sv */
// link between the pwm core and one dead-band delay unit
`timescale 1ns/1ns
`default_nettype none
interface deadband_if;
    logic       req;    // output wants to be active
    logic [6:0] count;  // delay in instruction cycles
    logic       grant;  // delayed active level
    modport core  (output req, output count, input grant);
    modport delay (input req, input count, output grant);
endinterface : deadband_if
`default_nettype wire

/* File: deadband_delay.sv */
// delays the inactive-to-active edge of one output
`timescale 1ns/1ns
`default_nettype none
module deadband_delay (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_b,
    // request and delayed grant
    deadband_if.delay   db
);
    logic [8:0] cnt_q;
    logic       grant_q;

    // reload while inactive, count down while requested
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 9'h000;
        end else if (!db.req) begin
            cnt_q <= 9'(db.count * bridge_pwm_pkg::TCY_CLKS);
        end else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
        end
    end

    // active only once the delay has run out while still requested
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            grant_q <= 1'b0;
        end else begin
            grant_q <= db.req && (cnt_q == 9'h000);
        end
    end

    assign db.grant = grant_q;

    // no grant while delay still counting
    holdOff_a: assert property (@(posedge clk) disable iff (!rst_b)
        db.req && cnt_q != 9'h000 |=> !grant_q)
        else $error("grant came before dead-band expired");

    // grant drops one cycle after request drops
    dropNow_a: assert property (@(posedge clk) disable iff (!rst_b)
        !db.req |=> !grant_q)
        else $error("grant held without request");
endmodule : deadband_delay
`default_nettype wire

/* File: enhanced_bridge_pwm_output.sv */
// enhanced pwm output stage: single, half-bridge and full-bridge outputs
`timescale 1ns/1ns
`default_nettype none
module enhanced_bridge_pwm_output (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // register port
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    // bridge outputs
    output logic            outA,
    output logic            outB,
    output logic            outC,
    output logic            outD
);
    // prescaler terminal count
    function automatic logic [5:0] preLast(input logic [1:0] ps);
        if (ps == bridge_pwm_pkg::PS_DIV1) begin
            return bridge_pwm_pkg::PRE_LAST1;
        end else if (ps == bridge_pwm_pkg::PS_DIV4) begin
            return bridge_pwm_pkg::PRE_LAST4;
        end
        return bridge_pwm_pkg::PRE_LAST16;
    endfunction : preLast

    // pwm mode decode
    function automatic logic isPwm(input logic [7:0] ctl);
        return ctl[bridge_pwm_pkg::CTL_MODE_HI -: 2] == bridge_pwm_pkg::MODE_PWM_SEL;
    endfunction : isPwm

    logic [7:0]  dutyHigh_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  period_q;
    logic [7:0]  dbReg_q;
    logic [2:0]  tmrCtl_q;
    logic [9:0]  dutyBuf_q;
    logic [7:0]  tmr_q;
    logic [5:0]  pre_q;
    logic [6:0]  dbAct_q;
    logic [1:0]  cfgAct_q;
    logic [3:0]  modeAct_q;
    logic        pwm_q;
    logic [7:0]  rdata_q;
    logic [3:0]  outs_q;
    logic [9:0]  dutyNext;
    logic [1:0]  sub;
    logic        tmrOn;
    logic        tick;
    logic        periodEnd;
    logic        dutyMatch;
    logic        pwmMod;
    logic        pwmOn;
    logic [3:0]  lvl;
    logic [3:0]  pol;
    bridge_pwm_pkg::outcfg_t cfg;

    deadband_if dbA ();
    deadband_if dbB ();

    // software register writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dutyHigh_q <= bridge_pwm_pkg::RST_REG;
            ctrl_q     <= bridge_pwm_pkg::RST_REG;
            period_q   <= bridge_pwm_pkg::RST_PERIOD;
            dbReg_q    <= bridge_pwm_pkg::RST_REG;
            tmrCtl_q   <= bridge_pwm_pkg::RST_REG[2:0];
        end else if (regWr) begin
            if (regAddr == bridge_pwm_pkg::OFF_DUTY_HIGH) begin
                dutyHigh_q <= regWdata;
            end else if (regAddr == bridge_pwm_pkg::OFF_CONTROL) begin
                ctrl_q <= regWdata;
            end else if (regAddr == bridge_pwm_pkg::OFF_PERIOD) begin
                period_q <= regWdata;
            end else if (regAddr == bridge_pwm_pkg::OFF_DEADBAND) begin
                dbReg_q <= regWdata;
            end else if (regAddr == bridge_pwm_pkg::OFF_TIMER_CTL) begin
                tmrCtl_q <= regWdata[2:0];
            end
        end
    end

    // ten-bit duty from high byte and two control bits
    assign dutyNext = {dutyHigh_q,
        ctrl_q[bridge_pwm_pkg::CTL_DLOW_HI:bridge_pwm_pkg::CTL_DLOW_LO]};

    // prescaled period timer
    assign tmrOn     = tmrCtl_q[bridge_pwm_pkg::TMR_ON_BIT];
    assign tick      = tmrOn && (pre_q == preLast(tmrCtl_q[1:0]));
    assign periodEnd = tick && (tmr_q == period_q);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= 6'h00;
        end else if (!tmrOn || tick) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_q <= 8'h00;
        end else if (periodEnd) begin
            tmr_q <= 8'h00;
        end else if (tick) begin
            tmr_q <= tmr_q + 8'h01;
        end
    end

    // sub-count: oscillator phase scaled by the prescale
    always_comb begin
        if (tmrCtl_q[1:0] == bridge_pwm_pkg::PS_DIV1) begin
            sub = pre_q[1:0];
        end else if (tmrCtl_q[1:0] == bridge_pwm_pkg::PS_DIV4) begin
            sub = pre_q[3:2];
        end else begin
            sub = pre_q[5:4];
        end
    end

    assign dutyMatch = ({tmr_q, sub} == dutyBuf_q);
    assign pwmMod    = pwm_q && !dutyMatch;

    // duty buffer: loaded at period end, writable only outside pwm mode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dutyBuf_q <= 10'h000;
        end else if (periodEnd) begin
            dutyBuf_q <= dutyNext;
        end else if (regWr && regAddr == bridge_pwm_pkg::OFF_DUTY_BUF && !isPwm(ctrl_q)) begin
            dutyBuf_q <= {regWdata, dutyBuf_q[1:0]};
        end
    end

    // control settings take effect at the period boundary
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgAct_q  <= 2'h0;
            modeAct_q <= 4'h0;
        end else if (periodEnd) begin
            cfgAct_q  <= ctrl_q[bridge_pwm_pkg::CTL_CFG_HI:bridge_pwm_pkg::CTL_CFG_LO];
            modeAct_q <= ctrl_q[bridge_pwm_pkg::CTL_MODE_HI:bridge_pwm_pkg::CTL_MODE_LO];
        end
    end

    // dead-band count applies at duty match or period end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dbAct_q <= 7'h00;
        end else if (periodEnd || (pwm_q && dutyMatch)) begin
            dbAct_q <= dbReg_q[bridge_pwm_pkg::DB_CNT_HI:0];
        end
    end

    // modulated signal: set at period end, cleared on duty match
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_q <= 1'b0;
        end else if (!isPwm(ctrl_q)) begin
            pwm_q <= 1'b0;
        end else if (periodEnd) begin
            pwm_q <= (dutyNext != 10'h000);
        end else if (dutyMatch) begin
            pwm_q <= 1'b0;
        end
    end

    // leaving pwm mode stops the outputs at once
    assign pwmOn = isPwm(ctrl_q) && (modeAct_q[3:2] == bridge_pwm_pkg::MODE_PWM_SEL);
    assign cfg   = bridge_pwm_pkg::outcfg_t'(cfgAct_q);

    // both half-bridge outputs share the same dead-band count
    assign dbA.req   = pwmMod;
    assign dbA.count = dbAct_q;
    assign dbB.req   = !pwmMod;
    assign dbB.count = dbAct_q;

    deadband_delay delayA (
        .clk   (clk),
        .rst_b (rst_b),
        .db    (dbA)
    );

    deadband_delay delayB (
        .clk   (clk),
        .rst_b (rst_b),
        .db    (dbB)
    );

    // logical active levels, index 0 is output a
    always_comb begin
        lvl = 4'h0;
        if (pwmOn) begin
            case (cfg)
                bridge_pwm_pkg::CFG_SINGLE: begin
                    lvl = {3'h0, pwmMod};
                end
                bridge_pwm_pkg::CFG_HALF: begin
                    lvl = {2'h0, dbB.grant, dbA.grant};
                end
                bridge_pwm_pkg::CFG_FULL_FWD: begin
                    lvl = {pwmMod, 2'h0, 1'b1};
                end
                default: begin
                    lvl = {1'b0, 1'b1, pwmMod, 1'b0};
                end
            endcase
        end
    end

    // polarity per pair: bit set means that pair is active low
    assign pol = {modeAct_q[bridge_pwm_pkg::MODE_POL_BD], modeAct_q[bridge_pwm_pkg::MODE_POL_AC],
                  modeAct_q[bridge_pwm_pkg::MODE_POL_BD], modeAct_q[bridge_pwm_pkg::MODE_POL_AC]};

    // registered pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outs_q <= 4'h0;
        end else begin
            outs_q <= pwmOn ? (lvl ^ pol) : 4'h0;
        end
    end

    assign outA = outs_q[0];
    assign outB = outs_q[1];
    assign outC = outs_q[2];
    assign outD = outs_q[3];

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (!regRd) begin
            rdata_q <= 8'h00;
        end else if (regAddr == bridge_pwm_pkg::OFF_DUTY_HIGH) begin
            rdata_q <= dutyHigh_q;
        end else if (regAddr == bridge_pwm_pkg::OFF_CONTROL) begin
            rdata_q <= ctrl_q;
        end else if (regAddr == bridge_pwm_pkg::OFF_PERIOD) begin
            rdata_q <= period_q;
        end else if (regAddr == bridge_pwm_pkg::OFF_DEADBAND) begin
            rdata_q <= dbReg_q;
        end else if (regAddr == bridge_pwm_pkg::OFF_DUTY_BUF) begin
            rdata_q <= dutyBuf_q[9:2];
        end else if (regAddr == bridge_pwm_pkg::OFF_TIMER_CTL) begin
            rdata_q <= {5'h00, tmrCtl_q};
        end else if (regAddr == bridge_pwm_pkg::OFF_TIMER) begin
            rdata_q <= tmr_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign regRdata = rdata_q;

    // buffer takes the written duty at period end
    dutyLoad_a: assert property (@(posedge clk) disable iff (!rst_b)
        periodEnd |=> dutyBuf_q == $past(dutyNext))
        else $error("duty buffer not loaded at period end");

    // timer restarts at period end
    timerClr_a: assert property (@(posedge clk) disable iff (!rst_b)
        periodEnd |=> tmr_q == 8'h00)
        else $error("timer not cleared at period end");

    // output set at period end unless duty zero
    outSet_a: assert property (@(posedge clk) disable iff (!rst_b)
        periodEnd && isPwm(ctrl_q) |=> pwm_q == $past(dutyNext != 10'h000))
        else $error("modulated output wrong after period end");

    // duty match clears the output
    outClear_a: assert property (@(posedge clk) disable iff (!rst_b)
        pwm_q && dutyMatch && !periodEnd |=> !pwm_q)
        else $error("output not cleared on duty match");

    // buffer unchanged by writes in pwm mode
    bufferRo_a: assert property (@(posedge clk) disable iff (!rst_b)
        regWr && regAddr == bridge_pwm_pkg::OFF_DUTY_BUF && isPwm(ctrl_q) && !periodEnd
        |=> $stable(dutyBuf_q))
        else $error("duty buffer written in pwm mode");

    // long duty keeps output set through the period
    longDuty_a: assert property (@(posedge clk) disable iff (!rst_b)
        pwm_q && isPwm(ctrl_q) && dutyBuf_q > {period_q, 2'h3} && !periodEnd |=> pwm_q)
        else $error("output cleared although duty exceeds period");

    // full forward levels
    fullFwd_a: assert property (@(posedge clk) disable iff (!rst_b)
        pwmOn && cfg == bridge_pwm_pkg::CFG_FULL_FWD |-> lvl == {pwmMod, 3'h1})
        else $error("forward full-bridge levels wrong");

    // full reverse levels
    fullRev_a: assert property (@(posedge clk) disable iff (!rst_b)
        pwmOn && cfg == bridge_pwm_pkg::CFG_FULL_REV |-> lvl == {2'h1, pwmMod, 1'b0})
        else $error("reverse full-bridge levels wrong");

    // at most two active in full-bridge
    twoActive_a: assert property (@(posedge clk) disable iff (!rst_b)
        cfg == bridge_pwm_pkg::CFG_FULL_FWD || cfg == bridge_pwm_pkg::CFG_FULL_REV
        |-> $countones(lvl) <= 2)
        else $error("more than two bridge outputs active");

    // single mode only output a
    singleOnly_a: assert property (@(posedge clk) disable iff (!rst_b)
        pwmOn && cfg == bridge_pwm_pkg::CFG_SINGLE |-> lvl == {3'h0, pwmMod})
        else $error("single mode drives other outputs");

    // half-bridge outputs never active together
    halfApart_a: assert property (@(posedge clk) disable iff (!rst_b)
        cfg == bridge_pwm_pkg::CFG_HALF |-> !(lvl[0] && lvl[1]))
        else $error("half-bridge outputs overlap");

    // pins follow levels and polarity one cycle later
    pinPol_a: assert property (@(posedge clk) disable iff (!rst_b)
        pwmOn ##1 1'b1 |-> {outD, outC, outB, outA} == $past(lvl ^ pol))
        else $error("pin polarity wrong");
endmodule : enhanced_bridge_pwm_output
`default_nettype wire

/* File: power_stage_model.sv */
// gate driver model of both bridge legs, counts shoot-through cycles
`timescale 1ns/1ns
`default_nettype none
module power_stage_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // observation window and pair polarity
    input  wire logic        watch,
    input  wire logic        lowAC,
    input  wire logic        lowBD,
    // bridge drives
    input  wire logic        outA,
    input  wire logic        outB,
    input  wire logic        outC,
    input  wire logic        outD,
    // cycles with both switches of one leg on
    output logic      [15:0] shootCount
);
    logic onA;
    logic onB;
    logic onC;
    logic onD;

    // a switch conducts when its drive sits at the active level
    assign onA = outA ^ lowAC;
    assign onB = outB ^ lowBD;
    assign onC = outC ^ lowAC;
    assign onD = outD ^ lowBD;

    // upper and lower of one leg together short the supply
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shootCount <= 16'h0000;
        end else if (watch && ((onA && onB) || (onC && onD))) begin
            shootCount <= shootCount + 16'h0001;
        end
    end
endmodule : power_stage_model
`default_nettype wire

/* File: enhanced_bridge_pwm_output_tb.sv */
// self-checking bench for the enhanced bridge pwm output stage
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); fail_count++; end end
module enhanced_bridge_pwm_output_tb;
    logic        clk;
    logic        rst_b;
    logic [2:0]  regAddr;
    logic [7:0]  regWdata;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdata;
    logic        outA;
    logic        outB;
    logic        outC;
    logic        outD;
    logic        watch;
    logic        lowAC;
    logic        lowBD;
    logic [15:0] shootCount;
    int          fail_count;
    int          samples_checked;
    int          ones [4];
    string       pinName [4] = '{"outA", "outB", "outC", "outD"};
    int          halfDuty [4] = '{10, 4, 8, 2};
    int          halfDb [4] = '{1, 0, 3, 1};

    enhanced_bridge_pwm_output DUT (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .outA(outA), .outB(outB), .outC(outC), .outD(outD));

    power_stage_model driverModel (.clk(clk), .rst_b(rst_b), .watch(watch), .lowAC(lowAC),
        .lowBD(lowBD), .outA(outA), .outB(outB), .outC(outC), .outD(outD),
        .shootCount(shootCount));

    // prints counts and verdict, ends the run
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        @(negedge clk);
        d = regRdata;
    endtask : rd

    // expected pin-high clocks over four periods of sixteen duty steps
    function automatic int expOnes(int k, logic [1:0] cfg, logic [3:0] mode, int d, int psv,
                                   int db);
        int   p;
        int   h;
        int   act;
        logic pol;
        p = 16 * psv;
        h = ((d > 16) ? 16 : d) * psv;
        case (cfg)
            2'b00: act = (k == 0) ? h : 0;
            2'b10: act = (k == 0) ? h - 4 * db : ((k == 1) ? p - h - 4 * db : 0);
            2'b01: act = (k == 0) ? p : ((k == 3) ? h : 0);
            default: act = (k == 2) ? p : ((k == 1) ? h : 0);
        endcase
        act = (act < 0) ? 0 : act;
        pol = (k == 0 || k == 2) ? mode[1] : mode[0];
        return 4 * (pol ? p - act : act);
    endfunction : expOnes

    // configure, let settings latch, then count high clocks per pin
    task automatic run(input logic [1:0] cfg, input logic [3:0] mode, input int d,
                       input logic [1:0] ps, input int db);
        int psv;
        psv = (ps == 2'b00) ? 1 : ((ps == 2'b01) ? 4 : 16);
        wr(bridge_pwm_pkg::OFF_DUTY_HIGH, 8'(d >> 2));
        wr(bridge_pwm_pkg::OFF_DEADBAND, 8'(db));
        wr(bridge_pwm_pkg::OFF_CONTROL, {cfg, 2'(d), mode});
        wr(bridge_pwm_pkg::OFF_TIMER_CTL, {5'h00, 1'b1, ps});
        repeat (48 * psv + 96) @(posedge clk);
        lowAC <= mode[1];
        lowBD <= mode[0];
        watch <= 1'b1;
        ones = '{0, 0, 0, 0};
        repeat (64 * psv) begin
            @(negedge clk);
            ones[0] += int'(outA === 1'b1);
            ones[1] += int'(outB === 1'b1);
            ones[2] += int'(outC === 1'b1);
            ones[3] += int'(outD === 1'b1);
        end
        watch <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            `CHK(pinName[k], expOnes(k, cfg, mode, d, psv, db), ones[k])
        end
    endtask : run

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // bound on the whole run
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        summarize();
    end

    // main sequence
    initial begin
        logic [7:0] v;
        logic [7:0] w;
        int         i;
        rst_b = 1'b0;
        regAddr = 3'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        watch = 1'b0;
        lowAC = 1'b0;
        lowBD = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        void'($urandom(2486));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // reset values, unmapped and read-only places
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), v);
            `CHK("reset value", (a == 2) ? 8'hff : 8'h00, v)
        end
        @(negedge clk);
        `CHK("read data idle", 8'h00, regRdata)
        v = 8'($urandom);
        wr(bridge_pwm_pkg::OFF_DUTY_HIGH, v);
        rd(bridge_pwm_pkg::OFF_DUTY_HIGH, w);
        `CHK("duty high", v, w)
        wr(bridge_pwm_pkg::OFF_TIMER, 8'h5a);
        wr(3'h7, 8'ha5);
        rd(bridge_pwm_pkg::OFF_TIMER, v);
        `CHK("timer", 8'h00, v)
        rd(3'h7, v);
        `CHK("unmapped", 8'h00, v)
        wr(bridge_pwm_pkg::OFF_PERIOD, 8'h03);
        // single output over every prescale, zero and overlong duty corners
        for (int ps = 0; ps < 3; ps++) begin
            for (int n = 0; n < 5; n++) begin
                i = (n == 0) ? 0 : ((n == 1) ? 17 : $urandom_range(16, 1));
                run(2'b00, 4'hc, i, 2'(ps), 0);
            end
        end
        // full bridge both directions under every polarity mode
        for (int m = 12; m < 16; m++) begin
            run(2'b01, 4'(m), $urandom_range(15, 1), 2'b00, 0);
            run(2'b11, 4'(m), $urandom_range(15, 1), 2'b00, 0);
        end
        // half bridge with dead-band, some longer than the active time
        for (int n = 0; n < 4; n++) begin
            run(2'b10, 4'hc, halfDuty[n], 2'b00, halfDb[n]);
        end
        `CHK("shoot-through cycles", 16'h0000, shootCount)
        // duty buffer loads only at period end and refuses writes in pwm mode
        wr(bridge_pwm_pkg::OFF_PERIOD, 8'h3f);
        wr(bridge_pwm_pkg::OFF_DUTY_HIGH, 8'h21);
        wr(bridge_pwm_pkg::OFF_CONTROL, 8'h0c);
        repeat (600) @(posedge clk);
        rd(bridge_pwm_pkg::OFF_DUTY_BUF, v);
        `CHK("duty buffer", 8'h21, v)
        rd(bridge_pwm_pkg::OFF_TIMER, v);
        for (i = 0; i < 300 && v > 8'h10; i++) begin
            rd(bridge_pwm_pkg::OFF_TIMER, v);
        end
        if (i >= 300) begin
            fail_count++;
            summarize();
        end
        wr(bridge_pwm_pkg::OFF_DUTY_HIGH, 8'h35);
        rd(bridge_pwm_pkg::OFF_DUTY_BUF, v);
        `CHK("duty buffer early", 8'h21, v)
        wr(bridge_pwm_pkg::OFF_DUTY_BUF, 8'haa);
        rd(bridge_pwm_pkg::OFF_DUTY_BUF, v);
        `CHK("duty buffer write", 8'h21, v)
        repeat (300) @(posedge clk);
        rd(bridge_pwm_pkg::OFF_DUTY_BUF, v);
        `CHK("duty buffer loaded", 8'h35, v)
        // leaving pwm mode drops outA and frees the buffer
        wr(bridge_pwm_pkg::OFF_CONTROL, 8'h00);
        repeat (3) @(negedge clk);
        `CHK("outA off", 1'b0, outA)
        wr(bridge_pwm_pkg::OFF_DUTY_BUF, 8'h5a);
        rd(bridge_pwm_pkg::OFF_DUTY_BUF, v);
        `CHK("duty buffer free", 8'h5a, v)
        summarize();
    end
endmodule : enhanced_bridge_pwm_output_tb
`default_nettype wire
